// *** opseq_status.sv ***
// opseq_status: operation status registers, transition filters, error queue and self-test
// assumes a command decoder that gives one-cycle strobes and takes registered answers
`timescale 1ns/10ps
module opseq_status
  import opseq_pkg::*;
#(
  parameter int unsigned DEPTH = OPSEQ_QDEPTH,
  parameter int unsigned CODE_W = OPSEQ_CODE_W,
  parameter int unsigned MSG_W = OPSEQ_MSG_W
) (
  // clock and resets
  input wire logic clk,
  input wire logic arst_n,
  input wire logic instrReset,
  input wire logic clearStatus,
  // operation condition sources
  input wire logic [14:0] condIn,
  // filter and enable writes and reads
  input wire logic negFiltWr,
  input wire logic posFiltWr,
  input wire logic opEnableWr,
  input wire logic srEnableWr,
  input wire logic [15:0] wrData,
  output logic [15:0] negFilt,
  output logic [15:0] posFilt,
  output logic [15:0] opEnable,
  output logic [7:0] srEnable,
  // condition and event reads
  input wire logic eventRd,
  output logic [15:0] eventData,
  output logic [15:0] condData,
  // error reporting
  input wire logic errPush,
  input wire logic [CODE_W-1:0] errCode,
  input wire logic [MSG_W-1:0] errMsg,
  input wire logic errPop,
  output logic [CODE_W-1:0] errOutCode,
  output logic [MSG_W-1:0] errOutMsg,
  output logic [4:0] errCount,
  output logic errOverflow,
  // self-test
  input wire logic testStart,
  input wire logic testDone,
  input wire logic testFail,
  input wire logic [15:0] testDiag,
  input wire logic cmdNonQuery,
  output logic [1:0] testResult,
  output logic [15:0] testCode,
  // summary
  input wire logic [6:0] stbOther,
  output logic [7:0] statusByte,
  output logic serviceReq
);
  // ****************************************************************
  // status registers
  // ****************************************************************
  logic [15:0] negFilt_q, negFilt_d, posFilt_q, posFilt_d;
  logic [15:0] opEna_q, opEna_d, cond_q, cond_d, event_q, event_d;
  logic [7:0] sre_q, sre_d;
  logic [15:0] evRd_q, evRd_d;
  logic testRun;

  always_comb
  begin
    negFilt_d = negFilt_q;
    posFilt_d = posFilt_q;
    opEna_d = opEna_q;
    sre_d = sre_q;
    // instrReset intentionally not used here: filters and enable keep their values
    if (negFiltWr) negFilt_d = wrData;
    if (posFiltWr) posFilt_d = wrData;
    if (opEnableWr) opEna_d = wrData;
    if (srEnableWr) sre_d = wrData[7:0];
    cond_d = {condIn, 1'b0};
    cond_d[OPSEQ_COND_TEST_BIT] = testRun;
    event_d = event_q;
    evRd_d = evRd_q;
    if (eventRd)
    begin
      evRd_d = event_q;
      event_d = '0;
    end
    if (clearStatus) event_d = '0;
    // new edges set after the clear so a coincident event is kept
    event_d = event_d | (cond_d & ~cond_q & posFilt_q)
                      | (~cond_d & cond_q & negFilt_q);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      negFilt_q <= OPSEQ_FILT_RST;
      posFilt_q <= OPSEQ_FILT_RST;
      opEna_q <= OPSEQ_ENA_RST;
      sre_q <= OPSEQ_SRE_RST;
      cond_q <= '0;
      event_q <= '0;
      evRd_q <= '0;
    end
    else
    begin
      negFilt_q <= negFilt_d;
      posFilt_q <= posFilt_d;
      opEna_q <= opEna_d;
      sre_q <= sre_d;
      cond_q <= cond_d;
      event_q <= event_d;
      evRd_q <= evRd_d;
    end
  end

  assign negFilt = negFilt_q;
  assign posFilt = posFilt_q;
  assign opEnable = opEna_q;
  assign srEnable = sre_q;
  assign eventData = evRd_q;
  assign condData = cond_q;

  // ****************************************************************
  // status byte and service request
  // ****************************************************************
  logic [7:0] stb;
  always_comb
  begin
    stb = {1'b0, stbOther};
    stb[OPSEQ_STB_OPE_BIT] = |(event_q & opEna_q);
  end
  assign statusByte = stb;
  assign serviceReq = |(stb & sre_q);

  // ****************************************************************
  // self-test sequencer
  // ****************************************************************
  opseq_test_e tst_q, tst_d;
  logic [1:0] res_q, res_d;
  logic [15:0] diag_q, diag_d;
  logic busyErr;

  always_comb
  begin
    tst_d = tst_q;
    res_d = res_q;
    diag_d = diag_q;
    busyErr = 1'b0;
    case (tst_q)
      TEST_IDLE:
        if (testStart)
        begin
          tst_d = TEST_RUN;
          res_d = OPSEQ_TEST_BUSY;
        end
      TEST_RUN:
      begin
        // the test is never aborted; stray commands only log an error
        busyErr = cmdNonQuery | testStart;
        if (testDone)
        begin
          tst_d = TEST_IDLE;
          res_d = testFail ? OPSEQ_TEST_FAIL : OPSEQ_TEST_PASS;
          diag_d = testDiag;
        end
      end
      default: tst_d = TEST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tst_q <= TEST_IDLE;
      res_q <= OPSEQ_TEST_PASS;
      diag_q <= '0;
    end
    else
    begin
      tst_q <= tst_d;
      res_q <= res_d;
      diag_q <= diag_d;
    end
  end

  assign testRun = (tst_q == TEST_RUN);
  assign testResult = res_q;
  assign testCode = diag_q;

  // ****************************************************************
  // error queue
  // ****************************************************************
  localparam int unsigned PW = $clog2(DEPTH);
  logic [CODE_W-1:0] qCode [DEPTH];
  logic [MSG_W-1:0] qMsg [DEPTH];
  logic [PW-1:0] rdPtr_q, rdPtr_d, wrPtr_q, wrPtr_d;
  logic [PW:0] cnt_q, cnt_d;
  logic ovf_q, ovf_d, ovfOn_q, ovfOn_d;
  logic [CODE_W-1:0] outCode_q, outCode_d;
  logic [MSG_W-1:0] outMsg_q, outMsg_d;
  logic anyErr, full, doPop, doWr, ovfWr;
  logic [PW-1:0] wrIdx;
  logic [CODE_W-1:0] wrCode;
  logic [MSG_W-1:0] wrMsg;

  assign anyErr = errPush | busyErr;
  assign full = (cnt_q == (PW+1)'(DEPTH));
  assign doPop = errPop && (cnt_q != '0);

  always_comb
  begin
    rdPtr_d = rdPtr_q;
    wrPtr_d = wrPtr_q;
    cnt_d = cnt_q;
    ovf_d = 1'b0;
    outCode_d = outCode_q;
    outMsg_d = outMsg_q;
    doWr = 1'b0;
    ovfWr = 1'b0;
    wrIdx = wrPtr_q;
    wrCode = busyErr ? OPSEQ_BUSY_CODE : errCode;
    wrMsg = busyErr ? OPSEQ_BUSY_MSG : errMsg;
    if (errPop)
    begin
      outCode_d = doPop ? qCode[rdPtr_q] : OPSEQ_EMPTY_CODE;
      outMsg_d = doPop ? qMsg[rdPtr_q] : OPSEQ_EMPTY_MSG;
    end
    if (doPop)
    begin
      rdPtr_d = rdPtr_q + 1'b1;
      cnt_d = cnt_q - 1'b1;
    end
    if (anyErr)
    begin
      if (!full || doPop)
      begin
        doWr = 1'b1;
        wrPtr_d = wrPtr_q + 1'b1;
        cnt_d = cnt_d + 1'b1;
      end
      else if (!ovfOn_q)
      begin
        // newest slot replaced once; later errors dropped until a pop
        ovfWr = 1'b1;
        wrIdx = wrPtr_q - 1'b1;
        wrCode = OPSEQ_OVF_CODE;
        wrMsg = OPSEQ_OVF_MSG;
        ovf_d = 1'b1;
      end
    end
    if (clearStatus)
    begin
      rdPtr_d = '0;
      wrPtr_d = '0;
      cnt_d = '0;
      doWr = 1'b0;
      ovfWr = 1'b0;
      // the dropped error goes with the emptied queue, so no overflow is reported
      ovf_d = 1'b0;
    end
  end

  always_comb
  begin
    ovfOn_d = ovfOn_q;
    if (ovfWr) ovfOn_d = 1'b1;
    if (doPop || clearStatus) ovfOn_d = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (doWr || ovfWr)
    begin
      qCode[wrIdx] <= wrCode;
      qMsg[wrIdx] <= wrMsg;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdPtr_q <= '0;
      wrPtr_q <= '0;
      cnt_q <= '0;
      ovf_q <= 1'b0;
      ovfOn_q <= 1'b0;
      outCode_q <= '0;
      outMsg_q <= '0;
    end
    else
    begin
      rdPtr_q <= rdPtr_d;
      wrPtr_q <= wrPtr_d;
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
      ovfOn_q <= ovfOn_d;
      outCode_q <= outCode_d;
      outMsg_q <= outMsg_d;
    end
  end

  assign errOutCode = outCode_q;
  assign errOutMsg = outMsg_q;
  assign errCount = 5'(cnt_q);
  assign errOverflow = ovf_q;
endmodule : opseq_status

// *** opseq_pkg.sv ***
// opseq_pkg: shared constants for the operation status and error queue block
// assumes a single 100 MHz clock domain and a command decoder outside the block
package opseq_pkg;
  // ****************************************************************
  // widths and reset values
  // ****************************************************************
  localparam int unsigned OPSEQ_REG_W = 16;
  localparam logic [15:0] OPSEQ_FILT_RST = 16'h0000;
  localparam logic [15:0] OPSEQ_ENA_RST = 16'h0000;
  localparam logic [7:0] OPSEQ_SRE_RST = 8'h00;
  localparam int unsigned OPSEQ_QDEPTH = 16;
  localparam int unsigned OPSEQ_CODE_W = 16;
  localparam int unsigned OPSEQ_MSG_W = 8;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned OPSEQ_STB_OPE_BIT = 7;
  localparam int unsigned OPSEQ_ESR_DDE_BIT = 3;
  localparam int unsigned OPSEQ_COND_TEST_BIT = 0;
  // ****************************************************************
  // codes
  // ****************************************************************
  localparam logic [1:0] OPSEQ_TEST_PASS = 2'h0;
  localparam logic [1:0] OPSEQ_TEST_FAIL = 2'h1;
  localparam logic [1:0] OPSEQ_TEST_BUSY = 2'h2;
  localparam logic [15:0] OPSEQ_OVF_CODE = 16'hFEFE;
  localparam logic [7:0] OPSEQ_OVF_MSG = 8'h01;
  localparam logic [15:0] OPSEQ_BUSY_CODE = 16'hFEFD;
  localparam logic [7:0] OPSEQ_BUSY_MSG = 8'h02;
  localparam logic [15:0] OPSEQ_EMPTY_CODE = 16'h0000;
  localparam logic [7:0] OPSEQ_EMPTY_MSG = 8'h00;
  typedef enum logic [0:0] {
    TEST_IDLE,
    TEST_RUN
  } opseq_test_e;
endpackage : opseq_pkg

// *** opseq_status_props.sv ***
// opseq_status_props: port-level checks on opseq_status
// assumes one clock domain; bound to the design at the foot of this file
`timescale 1ns/10ps
module opseq_status_chk
  import opseq_pkg::*;
(
  // strobes and data in
  input wire logic clk,
  input wire logic arst_n,
  input wire logic instrReset,
  input wire logic clearStatus,
  input wire logic negFiltWr,
  input wire logic posFiltWr,
  input wire logic [15:0] wrData,
  input wire logic errPush,
  input wire logic errPop,
  input wire logic testStart,
  input wire logic cmdNonQuery,
  // observed outputs
  input wire logic [15:0] negFilt,
  input wire logic [15:0] posFilt,
  input wire logic [7:0] statusByte,
  input wire logic [7:0] srEnable,
  input wire logic serviceReq,
  input wire logic [4:0] errCount,
  input wire logic errOverflow,
  input wire logic [1:0] testResult,
  input wire logic [15:0] condData
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence testLaunch;
    testStart && testResult != OPSEQ_TEST_BUSY;
  endsequence
  sequence testShown;
    // condition bit follows the registered test state, so it lags the result by one cycle
    testResult == OPSEQ_TEST_BUSY ##1 condData[OPSEQ_COND_TEST_BIT];
  endsequence
  chk_srq_level: assert property (serviceReq == |(statusByte & srEnable))
    else $error("service request level wrong");
  chk_neg_write: assert property (negFiltWr |=> negFilt == $past(wrData))
    else $error("negative filter write lost");
  chk_pos_write: assert property (posFiltWr |=> posFilt == $past(wrData))
    else $error("positive filter write lost");
  chk_filt_keep: assert property (instrReset && !negFiltWr && !posFiltWr |=>
    $stable(negFilt) && $stable(posFilt)) else $error("filters changed by reset");
  chk_test_busy: assert property (testLaunch |=> testShown)
    else $error("test start not shown");
  // push, pop and clear in the same cycle would blur the count, so excluded
  chk_busy_log: assert property (testResult == OPSEQ_TEST_BUSY && cmdNonQuery
    && !testStart && !errPush && !errPop && !clearStatus && errCount < 5'h10
    |=> errCount == $past(errCount) + 5'h01) else $error("busy command not logged");
  chk_queue_clear: assert property (clearStatus |=> errCount == 5'h00)
    else $error("clear left entries");
  chk_ovf_full: assert property (errOverflow |-> errCount == 5'h10)
    else $error("overflow without full queue");
endmodule : opseq_status_chk
bind opseq_status opseq_status_chk opseq_status_chk_inst (
  .clk, .arst_n, .instrReset, .clearStatus, .negFiltWr, .posFiltWr, .wrData,
  .errPush, .errPop, .testStart, .cmdNonQuery, .negFilt, .posFilt, .statusByte,
  .srEnable, .serviceReq, .errCount, .errOverflow, .testResult, .condData
);

// *** opseq_engine_model.sv ***
// opseq_engine_model: self-test engine answering a start after LAT cycles
// assumes start is a one-cycle pulse on clk
`timescale 1ns/10ps
module opseq_engine_model #(
  parameter int LAT = 20
) (
  // clock
  input wire logic clk,
  input wire logic arst_n,
  // test handshake
  input wire logic start,
  input wire logic failSel,
  input wire logic [15:0] diagSel,
  output logic done,
  output logic fail,
  output logic [15:0] diag
);
  int cnt;
  // outside the done cycle the answer lines carry the inverse, not a kind value
  assign fail = done ? failSel : ~failSel;
  assign diag = done ? diagSel : ~diagSel;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt <= 0;
      done <= 1'b0;
    end
    else
    begin
      done <= (cnt == 1);
      cnt <= start ? LAT : (cnt > 0 ? cnt - 1 : 0);
    end
  end
endmodule : opseq_engine_model

// *** opseq_status_test.sv ***
// opseq_status_test: self-checking bench for opseq_status
// assumes the engine model and the bound checker
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch at %0t: %h not %h", $time, a, b); end end
module opseq_status_test;
  import opseq_pkg::*;
  localparam logic [15:0] DIAG = 16'hA5C3;
  logic clk = 1'b0, arst_n = 1'b0, instrReset = 1'b0, clearStatus = 1'b0;
  logic negFiltWr = 1'b0, posFiltWr = 1'b0, opEnableWr = 1'b0, srEnableWr = 1'b0;
  logic eventRd = 1'b0, errPush = 1'b0, errPop = 1'b0, testStart = 1'b0;
  logic cmdNonQuery = 1'b0, failSel = 1'b0, testDone, testFail, serviceReq, errOverflow;
  logic [14:0] condIn = 15'h0000;
  logic [15:0] wrData = 16'h0000, errCode = 16'h0000, testDiag;
  logic [7:0] errMsg = 8'h00, srEnable, errOutMsg, statusByte;
  logic [6:0] stbOther = 7'h00;
  logic [15:0] negFilt, posFilt, opEnable, eventData, condData, errOutCode, testCode;
  logic [4:0] errCount;
  logic [1:0] testResult;
  int bad_count = 0, check_count = 0, cycles = 0;
  opseq_status opseq_status_inst (.clk, .arst_n, .instrReset, .clearStatus, .condIn,
    .negFiltWr, .posFiltWr, .opEnableWr, .srEnableWr, .wrData, .negFilt, .posFilt,
    .opEnable, .srEnable, .eventRd, .eventData, .condData, .errPush, .errCode, .errMsg,
    .errPop, .errOutCode, .errOutMsg, .errCount, .errOverflow, .testStart, .testDone,
    .testFail, .testDiag, .cmdNonQuery, .testResult, .testCode, .stbOther, .statusByte,
    .serviceReq);
  opseq_engine_model opseq_engine_model_inst (.clk, .arst_n, .start(testStart), .failSel,
    .diagSel(DIAG), .done(testDone), .fail(testFail), .diag(testDiag));
  initial forever #5 clk = ~clk;
  // whole run needs well under 400 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      bad_count++;
      test_done();
    end
  end
  // ****************
  // helpers and scenarios
  // ****************
  task step;
    @(posedge clk);
    #1;
  endtask : step
  task automatic pulse(ref logic s);
    s = 1'b1;
    step();
    s = 1'b0;
  endtask : pulse
  task automatic wr(ref logic s, input logic [15:0] v);
    wrData = v;
    pulse(s);
  endtask : wr
  task test_done;
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  task t_regs;
    `CHK(negFilt, OPSEQ_FILT_RST)
    `CHK(posFilt, OPSEQ_FILT_RST)
    `CHK(opEnable, OPSEQ_ENA_RST)
    `CHK(testResult, OPSEQ_TEST_PASS)
    wr(negFiltWr, 16'hFFFF);
    wr(posFiltWr, 16'hFFFF);
    wr(opEnableWr, 16'hFFFF);
    pulse(instrReset);
    step();
    `CHK(negFilt, 16'hFFFF)
    `CHK(posFilt, 16'hFFFF)
    `CHK(opEnable, 16'hFFFF)
    arst_n = 1'b0;
    step();
    arst_n = 1'b1;
    `CHK(negFilt | posFilt, 16'h0000)
  endtask : t_regs
  task t_events;
    wr(posFiltWr, 16'h0002);
    wr(negFiltWr, 16'h0004);
    wr(opEnableWr, 16'h0002);
    wr(srEnableWr, 16'h0080);
    condIn = 15'h0003;
    repeat (2) step();
    condIn = 15'h0000;
    repeat (2) step();
    `CHK({statusByte[7], serviceReq}, 2'h3)
    pulse(eventRd);
    `CHK(eventData, 16'h0006)
    `CHK({statusByte[7], serviceReq}, 2'h0)
    `CHK(srEnable, 8'h80)
    stbOther = 7'h40;
    step();
    `CHK({statusByte, serviceReq}, 9'h080)
    stbOther = 7'h00;
    condIn = 15'h0001;
    repeat (2) step();
    pulse(clearStatus);
    pulse(eventRd);
    `CHK(eventData, 16'h0000)
  endtask : t_events
  task t_queue;
    errPush = 1'b1;
    for (int i = 0; i < 18; i++)
    begin
      errCode = 16'(i);
      errMsg = 8'(i);
      step();
      if (i == 16)
        `CHK(errOverflow, 1'b1)
    end
    errPush = 1'b0;
    errPop = 1'b1;
    `CHK(errCount, 5'h10)
    for (int k = 0; k < 16; k++)
    begin
      step();
      `CHK(errOutCode, k < 15 ? 16'(k) : OPSEQ_OVF_CODE)
      `CHK(errOutMsg, k < 15 ? 8'(k) : OPSEQ_OVF_MSG)
    end
    step();
    errPop = 1'b0;
    `CHK(errOutCode, OPSEQ_EMPTY_CODE)
    pulse(errPush);
    pulse(clearStatus);
    `CHK(errCount, 5'h00)
  endtask : t_queue
  task t_test(input logic f);
    failSel = f;
    pulse(testStart);
    `CHK(testResult, OPSEQ_TEST_BUSY)
    step();
    `CHK(condData[OPSEQ_COND_TEST_BIT], 1'b1)
    pulse(cmdNonQuery);
    `CHK(errCount, 5'h01)
    pulse(errPop);
    `CHK(errOutCode, OPSEQ_BUSY_CODE)
    for (int n = 0; n < 40 && testResult === OPSEQ_TEST_BUSY; n++)
      step();
    `CHK(testResult, f ? OPSEQ_TEST_FAIL : OPSEQ_TEST_PASS)
    `CHK(testCode, DIAG)
    step();
    `CHK(condData[OPSEQ_COND_TEST_BIT], 1'b0)
  endtask : t_test
  initial
  begin
    repeat (10) @(posedge clk);
    #1 arst_n = 1'b1;
    t_regs();
    t_events();
    t_queue();
    t_test(1'b1);
    t_test(1'b0);
    test_done();
  end
endmodule : opseq_status_test
